// ==== hw/hppc_glitch_filter.sv ====
// Noise filter for one active-low overcurrent input.
`timescale 1ns/1ns
module hppc_glitch_filter (
    // Clock, reset and enable.
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    // Raw and filtered levels, active low.
    input  wire logic i_raw_n,
    output logic      o_level_n
);
    import hppc_pkg::*;

    typedef struct packed {
        logic [OC_CNT_W-1:0] cnt;
        logic                level_n;
    } hppc_flt_st_t;

    hppc_flt_st_t st_q;
    hppc_flt_st_t st_d;

    // The count restarts whenever the input agrees with the output, so a spike shorter than
    // the filter time never reaches the port logic.
    always_comb begin
        st_d = st_q;
        if (i_raw_n == st_q.level_n) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == OC_CNT_MAX) begin
            st_d.level_n = i_raw_n;
            st_d.cnt     = '0;
        end else begin
            st_d.cnt = st_q.cnt + OC_CNT_W'(1);
        end
    end

    // Idle level is "no overcurrent".
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= '{cnt: '0, level_n: 1'b1};
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_level_n = st_q.level_n;

    // The output only moves once the count has run out.
    filter_hold_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && (st_q.cnt != OC_CNT_MAX) |=> $stable(o_level_n))
        else $error("Filtered level changed before the filter time.");

    filter_pass_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && (st_q.cnt == OC_CNT_MAX) && (i_raw_n != o_level_n) |=> o_level_n == $past(i_raw_n))
        else $error("Filtered level did not follow a held input.");
endmodule : hppc_glitch_filter

// ==== hw/hppc_top.sv ====
// Port power, overcurrent, serial memory pin and clock selection logic of a four-port hub.
//
// Operation
// - Memory select high: serial memory interface off, memory clock pin not driven.
// - Memory select low: memory clock pin is a tri-state clock output, weak pulldown.
// - Memory select low: shared pin is bidirectional memory data, weak pulldown.
// - Memory select high: shared pin level picks ganged or per-port mode, kept static.
// - One active-low overcurrent input per port; per-port mode ties each to its port.
// - Every overcurrent input passes a noise filter so spikes are ignored.
// - Four active-low push-pull power outputs: low means power on.
// - Active-low reset at power-up initialises all internal logic.
// - Suspend output is high in suspend, low in normal operation.
// - Clock select low: 6 MHz crystal with PLL; high: direct 48 MHz clock.
// - In 6 MHz operation a PLL makes the 48 MHz and 12 MHz clocks.
// - Static power-source input: high bus-powered, low self-powered.
// - Ganged mode: outputs switch together; any overcurrent turns every port off.
`timescale 1ns/1ns
module hppc_top (
    // Clock, reset and enable.
    input  wire logic                         i_clk,
    input  wire logic                         i_rstn,
    input  wire logic                         i_ce,
    // Avalon-MM register slave.
    input  wire logic [7:0]                   i_avs_address,
    input  wire logic                         i_avs_read,
    input  wire logic                         i_avs_write,
    input  wire logic [31:0]                  i_avs_writedata,
    input  wire logic [3:0]                   i_avs_byteenable,
    output logic      [31:0]                  o_avs_readdata,
    output logic                              o_avs_waitrequest,
    output logic                              o_irq,
    // Straps.
    input  wire logic                         i_external_memory_select_n,
    input  wire logic                         i_bus_powered_select,
    input  wire logic                         i_clock_source_select,
    // Serial memory clock and shared data or power mode pin.
    output logic                              o_eeprom_clock_pin,
    output logic                              o_eeprom_clock_pin_oe,
    input  wire logic                         i_shared_data_or_power_mode_pin,
    output logic                              o_shared_data_or_power_mode_pin,
    output logic                              o_shared_data_or_power_mode_pin_oe,
    // Downstream port power.
    input  wire logic [hppc_pkg::NUM_PORTS-1:0] i_port_overcurrent_n,
    output logic      [hppc_pkg::NUM_PORTS-1:0] o_port_power_enable_n,
    // Suspend and clock selection.
    output logic                              o_suspend_indicator,
    output logic                              o_core_clock_fast,
    output logic                              o_pll_enable
);
    import hppc_pkg::*;

    typedef struct packed {
        logic [3:0]  pwr_req;
        logic        susp_req;
        logic [3:0]  trip;
        logic [3:0]  oc_prev;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic        ee_clk;
        logic        ee_dout;
        logic        ee_doe;
        logic        ganged;
        logic        ee_en;
        logic        bus_pwr;
        logic        waitreq;
        logic [31:0] rdata;
        logic [3:0]  pwr_n;
        logic        susp;
        logic        irq;
        logic        clk_oe;
        logic        clk_o;
        logic        sh_oe;
        logic        sh_o;
        logic        fast;
        logic        pll_en;
    } hppc_st_t;

    localparam hppc_st_t ST_RST = '{
        pwr_req: PWR_REQ_RST, susp_req: 1'b0, trip: 4'h0, oc_prev: 4'h0,
        irq_stat: 4'h0, irq_mask: IRQ_MASK_RST, ee_clk: 1'b0, ee_dout: 1'b0,
        ee_doe: 1'b0, ganged: 1'b0, ee_en: 1'b0, bus_pwr: 1'b0, waitreq: 1'b1,
        rdata: RDATA_RST, pwr_n: 4'hf, susp: 1'b0, irq: 1'b0, clk_oe: 1'b0,
        clk_o: 1'b0, sh_oe: 1'b0, sh_o: 1'b0, fast: 1'b0, pll_en: 1'b1};

    hppc_st_t       st_q;
    hppc_st_t       st_d;
    logic [3:0]     oc_flt_n;
    logic [3:0]     oc_act;
    logic           wr_take;
    logic           rd_take;
    logic [3:0]     oc_onset;

    ////////////////////////////////////////////////////////////////////////////////
    // Overcurrent filters, one per downstream port.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_oc
        hppc_glitch_filter u_flt (
            .i_clk     (i_clk),
            .i_rstn    (i_rstn),
            .i_ce      (i_ce),
            .i_raw_n   (i_port_overcurrent_n[p]),
            .o_level_n (oc_flt_n[p])
        );
    end

    // A request is taken on the edge where waitrequest is seen low; only low-lane bytes hold
    // fields, so a write without byte 0 enabled changes nothing.
    assign wr_take = i_avs_write && !st_q.waitreq && i_avs_byteenable[0];
    assign rd_take = i_avs_read && !st_q.waitreq;

    // A port's event is its filtered fault appearing; a fault that simply stays is no news.
    assign oc_onset = ~oc_flt_n & ~st_q.oc_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        st_d = st_q;
        // In ganged mode the tied inputs are merged so any one of them trips all ports.
        oc_act = st_q.ganged ? {4{~&oc_flt_n}} : ~oc_flt_n;

        // Straps are resampled every cycle; the board keeps them static.
        st_d.ee_en   = !i_external_memory_select_n;
        st_d.ganged  = i_external_memory_select_n && i_shared_data_or_power_mode_pin;
        st_d.bus_pwr = i_bus_powered_select;

        // Clock source: direct fast clock bypasses and powers down the PLL.
        st_d.fast   = i_clock_source_select;
        st_d.pll_en = !i_clock_source_select;

        // Bus slave: one wait cycle, then a one-cycle answer with registered read data.
        st_d.waitreq = 1'b1;
        if ((i_avs_read || i_avs_write) && st_q.waitreq) begin
            st_d.waitreq = 1'b0;
            st_d.rdata   = RDATA_RST;
            if (i_avs_read) begin
                case (i_avs_address)
                    REG_CTRL: begin
                        st_d.rdata[CTRL_PWR_LSB +: 4] = st_q.pwr_req;
                        st_d.rdata[CTRL_SUSP]         = st_q.susp_req;
                    end
                    REG_STATUS: begin
                        st_d.rdata[STAT_OC_LSB +: 4] = ~oc_flt_n;
                        st_d.rdata[STAT_GANGED]      = st_q.ganged;
                        st_d.rdata[STAT_EE_EN]       = st_q.ee_en;
                        st_d.rdata[STAT_BUS_POWERED_SELECT]      = st_q.bus_pwr;
                        st_d.rdata[STAT_FASTCLK]     = st_q.fast;
                    end
                    REG_IRQ_STAT: st_d.rdata[3:0] = st_q.irq_stat;
                    REG_IRQ_MASK: st_d.rdata[3:0] = st_q.irq_mask;
                    REG_EE_PINS: begin
                        st_d.rdata[EE_CLK]  = st_q.ee_clk;
                        st_d.rdata[EE_DOUT] = st_q.ee_dout;
                        st_d.rdata[EE_DOE]  = st_q.ee_doe;
                        st_d.rdata[EE_DIN]  = i_shared_data_or_power_mode_pin;
                    end
                    default: st_d.rdata = RDATA_RST;
                endcase
            end
        end

        // Register writes; an unmapped address is answered and ignored.
        if (wr_take) begin
            case (i_avs_address)
                REG_CTRL: begin
                    st_d.pwr_req  = i_avs_writedata[CTRL_PWR_LSB +: 4];
                    st_d.susp_req = i_avs_writedata[CTRL_SUSP];
                end
                REG_IRQ_STAT: st_d.irq_stat = st_q.irq_stat & ~i_avs_writedata[3:0];
                REG_IRQ_MASK: st_d.irq_mask = i_avs_writedata[3:0];
                REG_EE_PINS: begin
                    st_d.ee_clk  = i_avs_writedata[EE_CLK];
                    st_d.ee_dout = i_avs_writedata[EE_DOUT];
                    st_d.ee_doe  = i_avs_writedata[EE_DOE];
                end
                default: st_d.ee_doe = st_q.ee_doe;
            endcase
        end

        // A trip stays until software drops that port's power request, so a port that
        // faulted does not switch back on by itself when the switch recovers.
        st_d.trip = (st_q.trip & st_d.pwr_req) | oc_act;
        if (st_q.ganged && (|oc_act)) begin
            st_d.trip = 4'hf;
        end

        // A new overcurrent sets its sticky bit; the set wins over a clear in the same cycle.
        st_d.oc_prev  = ~oc_flt_n;
        st_d.irq_stat = st_d.irq_stat | oc_onset;
        st_d.irq      = |(st_d.irq_stat & st_q.irq_mask);

        // Power outputs: low requests power; ganged mode follows the first request bit.
        if (st_q.ganged) begin
            st_d.pwr_n = {4{!(st_d.pwr_req[0] && !(|st_d.trip))}};
        end else begin
            st_d.pwr_n = ~(st_d.pwr_req & ~st_d.trip);
        end

        st_d.susp = st_d.susp_req;

        // Serial memory pins; with memory off neither is driven. The weak pulldowns sit in
        // the pad ring, so released pins settle low.
        st_d.clk_oe = !i_external_memory_select_n;
        st_d.clk_o  = !i_external_memory_select_n && st_d.ee_clk;
        st_d.sh_oe  = !i_external_memory_select_n && st_d.ee_doe;
        st_d.sh_o   = st_d.sh_oe && st_d.ee_dout;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset puts every port off and every pin released.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q <= ST_RST;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    // Outputs come straight from the state register.
    assign o_avs_readdata                    = st_q.rdata;
    assign o_avs_waitrequest                 = st_q.waitreq;
    assign o_irq                             = st_q.irq;
    assign o_eeprom_clock_pin                = st_q.clk_o;
    assign o_eeprom_clock_pin_oe             = st_q.clk_oe;
    assign o_shared_data_or_power_mode_pin   = st_q.sh_o;
    assign o_shared_data_or_power_mode_pin_oe = st_q.sh_oe;
    assign o_port_power_enable_n             = st_q.pwr_n;
    assign o_suspend_indicator               = st_q.susp;
    assign o_core_clock_fast                 = st_q.fast;
    assign o_pll_enable                      = st_q.pll_en;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    memclk_released_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_external_memory_select_n |=> !o_eeprom_clock_pin_oe && !o_eeprom_clock_pin)
        else $error("Memory clock driven while memory interface is off.");

    memclk_driven_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && !i_external_memory_select_n |=> o_eeprom_clock_pin_oe)
        else $error("Memory clock not driven while memory interface is on.");

    shared_pin_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> o_shared_data_or_power_mode_pin_oe ==
                 (!$past(i_external_memory_select_n) && $past(st_d.ee_doe)))
        else $error("Shared pin drive does not follow memory mode.");

    ganged_mode_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_external_memory_select_n |=> st_q.ganged == $past(i_shared_data_or_power_mode_pin))
        else $error("Power mode not taken from the shared pin.");

    perport_off_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && !st_q.ganged |=> (o_port_power_enable_n & ~$past(oc_flt_n)) == ~$past(oc_flt_n))
        else $error("Port left powered during its own overcurrent.");

    ganged_off_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && st_q.ganged && (oc_flt_n != 4'hf) |=> o_port_power_enable_n == 4'hf)
        else $error("Ganged overcurrent did not turn every port off.");

    ganged_together_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && st_q.ganged |=> o_port_power_enable_n == 4'h0 || o_port_power_enable_n == 4'hf)
        else $error("Ganged power outputs differ.");

    suspend_out_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && wr_take && (i_avs_address == REG_CTRL)
        |=> o_suspend_indicator == $past(i_avs_writedata[CTRL_SUSP]))
        else $error("Suspend output does not follow its request.");

    reset_init_a: assert property (
        @(posedge i_clk)
        !i_rstn |-> o_port_power_enable_n == 4'hf && !o_suspend_indicator && o_avs_waitrequest)
        else $error("Outputs not initialised during reset.");

    clock_select_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> o_core_clock_fast == $past(i_clock_source_select) &&
                 o_pll_enable == !$past(i_clock_source_select))
        else $error("Clock source selection wrong.");

    bus_answer_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("Bus request not answered after one wait cycle.");

    // An answer lasts one cycle, so a read still held at its edge is not answered twice.
    read_once_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && rd_take |=> o_avs_waitrequest)
        else $error("Read answer held for more than one cycle.");

    // A fault that appears as software clears its bit must still leave the bit set.
    oc_event_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && (oc_onset != 4'h0) |=> (st_q.irq_stat & $past(oc_onset)) == $past(oc_onset))
        else $error("Overcurrent onset not recorded.");

    // The power source strap is only reported, so a stale copy would go unnoticed elsewhere.
    bus_power_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce |=> st_q.bus_pwr == $past(i_bus_powered_select))
        else $error("Power source strap not taken.");
endmodule : hppc_top

// ==== inc/hppc_pkg.sv ====
// Constants shared by the hub port power and configuration block.
package hppc_pkg;
    // Core clock.
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Overcurrent noise filter: a level must hold this long to be believed.
    localparam int unsigned OC_FILTER_NS  = 1000;
    localparam int unsigned OC_FILTER_CYC = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OC_CNT_W      = 5;
    localparam logic [OC_CNT_W-1:0] OC_CNT_MAX = OC_CNT_W'(OC_FILTER_CYC - 1);
    // Number of downstream ports.
    localparam int unsigned NUM_PORTS = 4;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT  = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK  = 8'h0c;
    localparam logic [7:0] REG_EE_PINS   = 8'h10;
    // Control register fields.
    localparam int unsigned CTRL_PWR_LSB = 0;
    localparam int unsigned CTRL_SUSP    = 4;
    // Status register fields.
    localparam int unsigned STAT_OC_LSB  = 0;
    localparam int unsigned STAT_GANGED  = 4;
    localparam int unsigned STAT_EE_EN   = 5;
    localparam int unsigned STAT_BUS_POWERED_SELECT  = 6;
    localparam int unsigned STAT_FASTCLK = 7;
    // Serial memory pin register fields.
    localparam int unsigned EE_CLK       = 0;
    localparam int unsigned EE_DOUT      = 1;
    localparam int unsigned EE_DOE       = 2;
    localparam int unsigned EE_DIN       = 3;
    // Reset values.
    localparam logic [3:0]  PWR_REQ_RST  = 4'h0;
    localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
    localparam logic [31:0] RDATA_RST    = 32'h0000_0000;
endpackage : hppc_pkg

// ==== verification/hppc_power_partner.sv ====
// Model of the downstream power switches, the board straps and the serial memory.
`timescale 1ns/1ns
module hppc_power_partner (
    // Commands from the bench.
    input  wire logic       i_mem_sel_n,
    input  wire logic       i_gang_strap,
    input  wire logic [3:0] i_overload,
    input  wire logic [3:0] i_spike,
    input  wire logic       i_mem_drive,
    input  wire logic       i_mem_bit,
    // Device pins.
    input  wire logic [3:0] i_power_n,
    input  wire logic       i_data_out,
    input  wire logic       i_data_oe,
    output logic      [3:0] o_overcurrent_n,
    output logic            o_data_pin
);
    logic [3:0] flag_n;
    // A switch flags while its port is powered and overloaded, or during a bench spike, so a trip self-clears.
    assign flag_n = ~((i_overload & ~i_power_n) | i_spike);
    // A ganged board ties all flag lines together, so one fault pulls every line low.
    assign o_overcurrent_n = (i_gang_strap && i_mem_sel_n) ? {4{&flag_n}} : flag_n;
    // Strap mode holds a static level; in memory mode the weak pulldown wins when idle.
    always_comb begin
        if (i_mem_sel_n) begin
            o_data_pin = i_gang_strap;
        end else if (i_data_oe) begin
            o_data_pin = i_data_out;
        end else if (i_mem_drive) begin
            o_data_pin = i_mem_bit;
        end else begin
            o_data_pin = 1'b0;
        end
    end
endmodule : hppc_power_partner

// ==== verification/tb_hppc_top.sv ====
// Self-checking bench for the hub port power and configuration block.
`timescale 1ns/1ns
module tb_hppc_top;
    import hppc_pkg::*;
    logic        i_clk, i_rstn, rd, wr, mem_sel_n, bus_pwr, clk_sel, gang, mem_drive, mem_bit;
    logic        waitreq, irq, ee_clk, ee_clk_oe, data_pin, data_out, data_oe, susp;
    logic        core_fast, pll_en, ce;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [3:0]  be, overload, spike, oc_n, pwr_n;
    int          fails, checks, cycles;
    // Shortest recommended reset pulse, 100 us of 50 ns cycles; the opening reset is shorter
    // only to keep the run brief.
    localparam int RST_HOLD_CYC = 2000;

    ////////////////////////////////////////////////////////////////////////////
    // Design and far side; the bench drives the clock enable so a freeze can be tested.
    hppc_top hppc_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(ce),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_irq(irq), .i_external_memory_select_n(mem_sel_n), .i_bus_powered_select(bus_pwr),
        .i_clock_source_select(clk_sel), .o_eeprom_clock_pin(ee_clk),
        .o_eeprom_clock_pin_oe(ee_clk_oe), .i_shared_data_or_power_mode_pin(data_pin),
        .o_shared_data_or_power_mode_pin(data_out),
        .o_shared_data_or_power_mode_pin_oe(data_oe), .i_port_overcurrent_n(oc_n),
        .o_port_power_enable_n(pwr_n), .o_suspend_indicator(susp),
        .o_core_clock_fast(core_fast), .o_pll_enable(pll_en));
    hppc_power_partner hppc_power_partner_i (.i_mem_sel_n(mem_sel_n), .i_gang_strap(gang),
        .i_overload(overload), .i_spike(spike), .i_mem_drive(mem_drive), .i_mem_bit(mem_bit),
        .i_power_n(pwr_n), .i_data_out(data_out), .i_data_oe(data_oe),
        .o_overcurrent_n(oc_n), .o_data_pin(data_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Clock runs from time zero, so it is active through every reset window.
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Verdict and end of run.
    task automatic test_done();
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // Comparisons of register words and of pin levels.
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: register read %h expected %h", $time, got, exp);
        end
    endtask : check_reg
    task automatic check_pin(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: pins %b expected %b", $time, got, exp);
        end
    endtask : check_pin

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick

    // Bus cycles hold the request until waitrequest is sampled low at an edge.
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        be    <= b;
        wr    <= 1'b1;
        do @(posedge i_clk); while (waitreq !== 1'b0);
        wr <= 1'b0;
    endtask : bus_write
    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        @(posedge i_clk);
        addr <= a;
        rd   <= 1'b1;
        do @(posedge i_clk); while (waitreq !== 1'b0);
        d = rdata;
        rd <= 1'b0;
        check_reg(d, exp);
    endtask : read_check

    // Reset falls in the step where the straps move, so no edge sees a moved strap outside
    // reset; outputs are checked while it is still held.
    task automatic do_reset(input int n);
        i_rstn <= 1'b0;
        tick(n);
        check_pin(pwr_n, 4'hf);
        check_pin({waitreq, irq, susp, ee_clk_oe | data_oe}, 4'h8);
        i_rstn <= 1'b1;
        tick(2);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    // A hang costs a mismatch; the two long resets make the run about 4,250 cycles.
    initial begin
        cycles = 0;
        forever begin
            @(posedge i_clk);
            cycles++;
            if (cycles == 8000) begin
                fails++;
                test_done();
            end
        end
    end

    initial begin
        // Reset starts high so that its first assertion is a real falling edge.
        i_rstn = 1'b1; rd = 1'b0; wr = 1'b0; addr = 8'h00; wdata = 32'h0; be = 4'hf;
        mem_sel_n = 1'b1; gang = 1'b0; bus_pwr = 1'b1; clk_sel = 1'b0;
        overload = 4'h0; spike = 4'h0; mem_drive = 1'b0; mem_bit = 1'b0;
        fails = 0;
        checks = 0;
        ce = 1'b1;
        // Per-port strap mode, bus powered, crystal clock.
        do_reset(3);
        check_pin({ee_clk_oe, data_oe, core_fast, pll_en}, 4'h1);
        read_check(REG_STATUS, 32'h40);
        read_check(REG_CTRL, 32'h0);
        read_check(REG_IRQ_MASK, 32'h0);
        bus_write(REG_CTRL, 32'h1f, 4'hf);
        tick(3);
        check_pin(pwr_n, 4'h0);
        check_pin({3'h0, susp}, 4'h1);
        // A spike one cycle short of the filter length must leave power alone.
        spike <= 4'h2;
        tick(19);
        spike <= 4'h0;
        tick(25);
        check_pin(pwr_n, 4'h0);
        // With the clock enable low a held fault must not advance the filter at all.
        ce    <= 1'b0;
        spike <= 4'h1;
        tick(25);
        ce    <= 1'b1;
        spike <= 4'h0;
        tick(3);
        check_pin(pwr_n, 4'h0);
        read_check(REG_IRQ_STAT, 32'h0);
        // A real fault on port 2 removes only that port, then raises a masked event.
        overload <= 4'h4;
        tick(25);
        check_pin(pwr_n, 4'h4);
        read_check(REG_STATUS, 32'h44);
        overload <= 4'h0;
        read_check(REG_IRQ_STAT, 32'h4);
        check_pin({3'h0, irq}, 4'h0);
        bus_write(REG_IRQ_MASK, 32'h4, 4'hf);
        tick(2);
        check_pin({3'h0, irq}, 4'h1);
        bus_write(REG_IRQ_STAT, 32'h4, 4'hf);
        tick(2);
        check_pin({3'h0, irq}, 4'h0);
        // Software clears the request, then powers the port again.
        tick(25);
        bus_write(REG_CTRL, 32'h1b, 4'hf);
        bus_write(REG_CTRL, 32'h1f, 4'hf);
        tick(3);
        check_pin(pwr_n, 4'h0);
        // Refused writes: unmapped, low byte disabled, read-only.
        bus_write(8'h14, 32'hff, 4'hf);
        read_check(8'h14, 32'h0);
        bus_write(REG_CTRL, 32'h0, 4'he);
        bus_write(REG_STATUS, 32'h0, 4'hf);
        tick(3);
        check_pin(pwr_n, 4'h0);
        read_check(REG_STATUS, 32'h40);
        // Ganged mode, self powered, direct fast clock: one fault drops every port.
        gang <= 1'b1;
        bus_pwr <= 1'b0;
        // The bench clock now stands for the direct fast oscillator.
        clk_sel <= 1'b1;
        do_reset(RST_HOLD_CYC);
        check_pin({2'h0, core_fast, pll_en}, 4'h2);
        read_check(REG_STATUS, 32'h90);
        bus_write(REG_CTRL, 32'h1, 4'hf);
        tick(3);
        check_pin(pwr_n, 4'h0);
        overload <= 4'h8;
        tick(25);
        check_pin(pwr_n, 4'hf);
        overload <= 4'h0;
        // Memory mode: clock pin driven, shared pin is bidirectional data.
        mem_sel_n <= 1'b0;
        gang <= 1'b0;
        do_reset(RST_HOLD_CYC);
        check_pin({ee_clk_oe, data_oe, 2'h0}, 4'h8);
        read_check(REG_STATUS, 32'ha0);
        bus_write(REG_EE_PINS, 32'h7, 4'hf);
        tick(2);
        check_pin({ee_clk, ee_clk_oe, data_out, data_oe}, 4'hf);
        read_check(REG_EE_PINS, 32'hf);
        mem_drive <= 1'b1;
        mem_bit <= 1'b1;
        bus_write(REG_EE_PINS, 32'h0, 4'hf);
        tick(2);
        check_pin({ee_clk, ee_clk_oe, data_out, data_oe}, 4'h4);
        read_check(REG_EE_PINS, 32'h8);
        mem_drive <= 1'b0;
        tick(2);
        read_check(REG_EE_PINS, 32'h0);
        test_done();
    end
endmodule : tb_hppc_top
